// ==== hw/smac_ctrl.sv ====
// Streamed MAC accumulator control: extension word, normalise, shift, streaming
`timescale 1ns/1ps
module smac_ctrl
    import smac_pkg::*;
#(
    parameter int WORD = 16
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [15:0] OPCODE,
    input wire logic OPCODE_VALID,
    input wire smac_pkg::smac_op_t OP,
    input wire logic LOOP_START,
    input wire logic [15:0] TOP_IN,
    input wire logic [15:0] NEXT_IN,
    input wire logic [15:0] PSTACK_IN,
    input wire logic [15:0] MEM_RDATA,
    input wire logic [15:0] BUS_RDATA,
    input wire logic [4:0] SRC_PORT,
    output logic [15:0] TOP,
    output logic [15:0] NEXT,
    output logic PUSH,
    output logic POP,
    output logic [15:0] PUSH_DATA,
    output logic [15:0] MEM_ADDR,
    output logic [4:0] BUS_PORT,
    output logic BUS_INTERNAL,
    output logic BUS_EXTERNAL,
    output logic [15:0] MAC_EXT,
    output logic [15:0] MAC_MID,
    output logic [15:0] MAC_LOW,
    output logic STREAMING,
    output logic INT_BLOCK
);
    import smac_pkg::*;

    typedef enum {S_IDLE, S_ARMED, S_LOOP, S_RUN} smac_state_t;
    smac_state_t state;
    logic src_bus;
    logic [15:0] count;
    logic [15:0] pipe;
    logic [5:0] lz_count;
    logic [31:0] lz_shifted;
    logic is_stream_op;
    logic [47:0] acc;
    logic [47:0] next_acc;
    logic [31:0] product;
    logic [15:0] op_a;
    logic [15:0] op_b;

    function automatic logic is_internal_port(input logic [4:0] p);
        return p <= INTERNAL_PORT_LAST;
    endfunction

    smac_lzc #(.W(32)) u_lzc (
        .din({TOP_IN, NEXT_IN}),
        .count(lz_count),
        .shifted(lz_shifted)
    );

    assign is_stream_op = OPCODE_VALID && OPCODE == OPC_MEM_STREAM;
    assign acc = {MAC_EXT, MAC_MID, MAC_LOW};

    // Streaming uses the pipeline register; plain MAC uses top
    always_comb begin
        op_a = (state == S_RUN && is_stream_op) ? pipe : TOP_IN;
        op_b = NEXT_IN;
        product = op_a * op_b;
        next_acc = acc + {16'h0000, product};
    end

    // Stream control state
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state <= S_IDLE;
            src_bus <= 1'b0;
            count <= COUNT_RESET;
        end else if (CE) begin
            case (state)
                S_IDLE: begin
                    if (OP == SMAC_OP_SETUP_BUS) begin
                        state <= S_ARMED;
                        src_bus <= 1'b1;
                    end else if (OP == SMAC_OP_SETUP_STACK) begin
                        state <= S_ARMED;
                        src_bus <= 1'b0;
                    end
                end
                S_ARMED: begin
                    // Loop start must follow directly; anything else drops the arming
                    if (LOOP_START) begin
                        state <= S_LOOP;
                        count <= TOP_IN;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_LOOP: begin
                    state <= is_stream_op ? S_RUN : S_IDLE;
                end
                S_RUN: begin
                    if (!is_stream_op || count == 16'h0000) begin
                        state <= S_IDLE;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Pipeline register: fed from bus port or stack every cycle
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pipe <= 16'h0000;
        end else if (CE) begin
            pipe <= src_bus ? BUS_RDATA : PSTACK_IN;
        end
    end

    // Accumulator
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            MAC_EXT <= ACC_RESET;
            MAC_MID <= ACC_RESET;
            MAC_LOW <= ACC_RESET;
        end else if (CE) begin
            if (state == S_RUN && is_stream_op) begin
                {MAC_EXT, MAC_MID, MAC_LOW} <= next_acc;
            end else begin
                case (OP)
                    SMAC_OP_EXT_STORE: MAC_EXT <= TOP_IN;
                    SMAC_OP_NORMALIZE: begin
                        MAC_EXT <= {10'h000, lz_count};
                        {MAC_MID, MAC_LOW} <= lz_shifted;
                    end
                    SMAC_OP_RSHIFT: begin
                        MAC_LOW <= MAC_MID;
                        MAC_MID <= MAC_EXT;
                        MAC_EXT <= {16{MAC_EXT[15]}};
                    end
                    SMAC_OP_MAC: {MAC_EXT, MAC_MID, MAC_LOW} <= next_acc;
                    default: ;
                endcase
            end
        end
    end

    // Stack effects
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            TOP <= 16'h0000;
            NEXT <= 16'h0000;
            PUSH <= 1'b0;
            POP <= 1'b0;
            PUSH_DATA <= 16'h0000;
            MEM_ADDR <= 16'h0000;
        end else if (CE) begin
            TOP <= TOP_IN;
            NEXT <= NEXT_IN;
            PUSH <= 1'b0;
            POP <= 1'b0;
            PUSH_DATA <= NEXT_IN;
            MEM_ADDR <= TOP_IN;
            if (is_stream_op) begin
                NEXT <= MEM_RDATA;
                TOP <= TOP_IN + {11'h000, OPCODE[4:0]};
            end else if (OP == SMAC_OP_EXT_FETCH) begin
                TOP <= MAC_EXT;
                NEXT <= TOP_IN;
                PUSH <= 1'b1;
            end else if (OP == SMAC_OP_EXT_STORE) begin
                TOP <= NEXT_IN;
                NEXT <= PSTACK_IN;
                POP <= 1'b1;
            end
        end
    end

    // Bus port and interrupt blocking
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            BUS_PORT <= 5'h00;
            BUS_INTERNAL <= 1'b0;
            BUS_EXTERNAL <= 1'b0;
            INT_BLOCK <= 1'b0;
            STREAMING <= 1'b0;
        end else if (CE) begin
            BUS_PORT <= SRC_PORT;
            BUS_INTERNAL <= src_bus && is_internal_port(SRC_PORT);
            BUS_EXTERNAL <= src_bus && !is_internal_port(SRC_PORT);
            INT_BLOCK <= OP == SMAC_OP_SETUP_BUS || OP == SMAC_OP_SETUP_STACK;
            STREAMING <= state == S_RUN;
        end
    end

    property p_setup_blocks;
        @(posedge CLOCK) disable iff (RST)
        CE && (OP == SMAC_OP_SETUP_BUS || OP == SMAC_OP_SETUP_STACK) |=> INT_BLOCK;
    endproperty
    a_setup_blocks: assert property (p_setup_blocks) else $error("no int block");

    property p_arm;
        @(posedge CLOCK) disable iff (RST)
        CE && state == S_IDLE && OP == SMAC_OP_SETUP_STACK |=> state == S_ARMED && !src_bus;
    endproperty
    a_arm: assert property (p_arm) else $error("stack setup not armed");

    property p_arm_bus;
        @(posedge CLOCK) disable iff (RST)
        CE && state == S_IDLE && OP == SMAC_OP_SETUP_BUS |=> state == S_ARMED && src_bus;
    endproperty
    a_arm_bus: assert property (p_arm_bus) else $error("bus setup not armed");

    property p_stream_addr;
        @(posedge CLOCK) disable iff (RST)
        CE && is_stream_op |=> TOP == $past(TOP_IN) + {11'h000, $past(OPCODE[4:0])};
    endproperty
    a_stream_addr: assert property (p_stream_addr) else $error("bad address step");

    property p_stream_acc;
        @(posedge CLOCK) disable iff (RST)
        CE && state == S_RUN && is_stream_op |=> acc == $past(next_acc);
    endproperty
    a_stream_acc: assert property (p_stream_acc) else $error("no accumulate");

    property p_end;
        @(posedge CLOCK) disable iff (RST)
        CE && state == S_RUN && count == 16'h0000 |=> state == S_IDLE;
    endproperty
    a_end: assert property (p_end) else $error("stream not ended");

    property p_rshift;
        @(posedge CLOCK) disable iff (RST)
        CE && state != S_RUN && OP == SMAC_OP_RSHIFT && !is_stream_op
        |=> MAC_LOW == $past(MAC_MID) && MAC_MID == $past(MAC_EXT)
            && MAC_EXT == {16{$past(MAC_EXT[15])}};
    endproperty
    a_rshift: assert property (p_rshift) else $error("bad right shift");

    property p_fetch;
        @(posedge CLOCK) disable iff (RST)
        CE && OP == SMAC_OP_EXT_FETCH && !is_stream_op |=> TOP == $past(MAC_EXT) && PUSH;
    endproperty
    a_fetch: assert property (p_fetch) else $error("bad ext fetch");

    property p_ext_store;
        @(posedge CLOCK) disable iff (RST)
        CE && OP == SMAC_OP_EXT_STORE && !is_stream_op
        |=> MAC_EXT == $past(TOP_IN) && TOP == $past(NEXT_IN) && POP;
    endproperty
    a_ext_store: assert property (p_ext_store) else $error("bad ext store");

    property p_leading_zero_normalize;
        @(posedge CLOCK) disable iff (RST)
        CE && OP == SMAC_OP_NORMALIZE && !is_stream_op
        |=> ({MAC_MID, MAC_LOW} >> MAC_EXT[5:0]) == $past({TOP_IN, NEXT_IN})
            && (MAC_MID[15] || MAC_EXT == 16'h0020);
    endproperty
    a_leading_zero_normalize: assert property (p_leading_zero_normalize) else $error("bad normalize");

    property p_mac;
        @(posedge CLOCK) disable iff (RST)
        CE && OP == SMAC_OP_MAC && !(state == S_RUN && is_stream_op)
        |=> acc == $past(acc) + $past(TOP_IN) * $past(NEXT_IN);
    endproperty
    a_mac: assert property (p_mac) else $error("bad plain accumulate");

    property p_run_step;
        @(posedge CLOCK) disable iff (RST)
        CE && state == S_RUN && is_stream_op && count != 16'h0000
        |=> state == S_RUN && count == $past(count) - 16'h0001;
    endproperty
    a_run_step: assert property (p_run_step) else $error("stream iteration lost");

    property p_stream_next;
        @(posedge CLOCK) disable iff (RST)
        CE && is_stream_op |=> NEXT == $past(MEM_RDATA) && MEM_ADDR == $past(TOP_IN);
    endproperty
    a_stream_next: assert property (p_stream_next) else $error("bad stream read");

    property p_bus_sel;
        @(posedge CLOCK) disable iff (RST)
        CE && src_bus
        |=> BUS_INTERNAL == ($past(SRC_PORT) <= INTERNAL_PORT_LAST) && BUS_EXTERNAL != BUS_INTERNAL;
    endproperty
    a_bus_sel: assert property (p_bus_sel) else $error("bad port routing");

    c_run: cover property (@(posedge CLOCK) state == S_RUN ##1 state == S_RUN);
    c_bus: cover property (@(posedge CLOCK) state == S_RUN && src_bus);
    c_leading_zero_normalize: cover property (@(posedge CLOCK) CE && OP == SMAC_OP_NORMALIZE);
    c_ext_port: cover property (@(posedge CLOCK) BUS_EXTERNAL && STREAMING);
endmodule

// ==== hw/smac_pkg.sv ====
// Package: opcodes, widths and constants for the streamed MAC control block
package smac_pkg;
    localparam int WORD_W = 16;
    localparam int ACC_W = 48;
    localparam int PORT_W = 5;
    localparam int LIT_W = 5;
    localparam logic [4:0] INTERNAL_PORT_LAST = 5'h17;
    localparam logic [15:0] OPC_MEM_STREAM = 16'he842;
    localparam logic [15:0] ACC_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    typedef enum logic [2:0] {
        SMAC_OP_NONE,
        SMAC_OP_EXT_FETCH,
        SMAC_OP_EXT_STORE,
        SMAC_OP_NORMALIZE,
        SMAC_OP_RSHIFT,
        SMAC_OP_MAC,
        SMAC_OP_SETUP_BUS,
        SMAC_OP_SETUP_STACK
    } smac_op_t;
endpackage

// ==== hw/smac_lzc.sv ====
// Leading-zero counter and left normaliser for a 32-bit double word
`timescale 1ns/1ps
module smac_lzc #(
    parameter int W = 32
) (
    input wire logic [W-1:0] din,
    output logic [5:0] count,
    output logic [W-1:0] shifted
);
    always_comb begin
        count = 6'(W);
        for (int i = 0; i < W; i++) begin
            if (din[i]) begin
                count = 6'(W - 1 - i);
            end
        end
        shifted = din << count;
    end
endmodule

// ==== dv/smac_far_model.sv ====
// Far-side model: data memory and peripheral port data
`timescale 1ns/1ps
module smac_far_model (
    input wire logic [15:0] ADDR,
    input wire logic [4:0] PORT,
    output logic [15:0] MEM_RDATA,
    output logic [15:0] BUS_RDATA
);
    // Data is a fixed function of address or port so stream sums stay predictable
    assign MEM_RDATA = ADDR ^ 16'h3c3c;
    assign BUS_RDATA = {11'h000, PORT} + 16'h0101;
endmodule

// ==== dv/tb_top.sv ====
// Testbench for the streamed MAC control block
`timescale 1ns/1ps
module tb_top;
    import smac_pkg::*;
    logic clock = 0, rst = 1, ce = 1, opv = 0, ls = 0, chk = 0;
    logic [15:0] opc = 0, top_in = 0, next_in = 0, ps_in = 0, mrd, brd, t, n, p, nv, pv, cnt;
    logic [4:0] sport = 0, bport;
    smac_op_t op = SMAC_OP_NONE;
    logic [15:0] top, nxt, pd, maddr, ext, mid, low;
    logic push, pop, bint, bext, strm, intb;
    logic [47:0] a = 0;
    logic [31:0] d;
    logic [80:0] q[$];
    int bad_count = 0, n_tests = 0, seed = 32'h92f039c3, i, lz;
    always #12.5 clock = ~clock;
    smac_ctrl DUT (.CLOCK(clock), .RST(rst), .CE(ce), .OPCODE(opc), .OPCODE_VALID(opv), .OP(op),
        .LOOP_START(ls), .TOP_IN(top_in), .NEXT_IN(next_in), .PSTACK_IN(ps_in), .MEM_RDATA(mrd),
        .BUS_RDATA(brd), .SRC_PORT(sport), .TOP(top), .NEXT(nxt), .PUSH(push), .POP(pop),
        .PUSH_DATA(pd), .MEM_ADDR(maddr), .BUS_PORT(bport), .BUS_INTERNAL(bint),
        .BUS_EXTERNAL(bext), .MAC_EXT(ext), .MAC_MID(mid), .MAC_LOW(low), .STREAMING(strm),
        .INT_BLOCK(intb));
    smac_far_model FAR (.ADDR(top_in), .PORT(bport), .MEM_RDATA(mrd), .BUS_RDATA(brd));
    task automatic cmp(logic [47:0] g, logic [47:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Drive one op at the falling edge and note what the next rising edge must show
    task automatic step(smac_op_t o, logic [15:0] tt, logic [15:0] nn, logic [15:0] pp,
        logic s, logic [31:0] tn);
        @(negedge clock);
        op = o;
        top_in = tt;
        next_in = nn;
        ps_in = pp;
        chk = 1;
        q.push_back({s, a, tn});
    endtask
    always @(posedge clock) begin
        #1;
        if (chk) begin
            if (q.size() == 0) cmp(48'h1, 48'h0);
            else begin
                cmp({ext, mid, low}, q[0][79:32]);
                if (q[0][80]) cmp(48'({top, nxt}), 48'(q[0][31:0]));
                void'(q.pop_front());
            end
        end
    end
    initial begin
        #(25 * 5000);
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (4) @(negedge clock);
        rst = 0;
        step(SMAC_OP_NONE, 0, 0, 0, 1, 0);
        for (i = 0; i < 4; i++) begin
            t = i ? 16'($random(seed)) : 16'h0;
            n = 16'($random(seed));
            p = 16'($random(seed));
            a[47:32] = t;
            step(SMAC_OP_EXT_STORE, t, n, p, 1, {n, p});
            step(SMAC_OP_EXT_FETCH, n, p, t, 1, {t, n});
            cmp(48'({push, pop}), 48'h1);
            a = a + 48'(t) * 48'(n);
            step(SMAC_OP_MAC, t, n, p, 0, 0);
            cmp(48'({push, pop, pd}), 48'({2'b10, p}));
            d = {t, i ? n : 16'h0};
            lz = 0;
            while (lz < 32 && !d[31 - lz]) lz++;
            a = {16'(lz), d << lz};
            step(SMAC_OP_NORMALIZE, t, d[15:0], p, 0, 0);
            a = {{16{a[47]}}, a[47:16]};
            step(SMAC_OP_RSHIFT, t, n, p, 0, 0);
        end
        // A stalled cycle must leave the accumulator alone
        step(SMAC_OP_MAC, 16'h1234, 16'h0005, 0, 0, 0);
        ce = 0;
        step(SMAC_OP_NONE, 0, 0, 0, 0, 0);
        ce = 1;
        for (i = 0; i < 3; i++) begin
            cnt = 16'(2 + i);
            sport = i == 1 ? 5'h17 : 5'h18;
            nv = 16'($random(seed));
            pv = 16'($random(seed));
            @(negedge clock);
            chk = 0;
            op = i ? SMAC_OP_SETUP_BUS : SMAC_OP_SETUP_STACK;
            @(negedge clock);
            op = SMAC_OP_NONE;
            ls = 1;
            top_in = cnt;
            cmp(48'(intb), 48'h1);
            @(negedge clock);
            ls = 0;
            opv = 1;
            opc = OPC_MEM_STREAM;
            top_in = 16'h0040;
            next_in = nv;
            ps_in = pv;
            repeat (2) @(negedge clock);
            cmp(48'(strm), 48'h1);
            cmp(48'({maddr, top, nxt}), 48'({16'h0040, 16'h0040 + 16'(OPC_MEM_STREAM[4:0]),
                16'h0040 ^ 16'h3c3c}));
            cmp(48'(bport), 48'(sport));
            if (i) cmp(48'({bint, bext}), i == 1 ? 48'h2 : 48'h1);
            repeat (cnt + 2) @(negedge clock);
            opv = 0;
            a = a + 48'(cnt + 1) * 48'(nv) * 48'(i ? {11'h000, sport} + 16'h0101 : pv);
            step(SMAC_OP_NONE, 0, 0, 0, 0, 0);
        end
        @(negedge clock);
        chk = 0;
        cmp(48'(strm), 48'h0);
        stop_test();
    end
endmodule
